// file: rtl/ssp_consts.vh
// constants for the serial programming latches of the synthesizer
// assumes inclusion by bare name from the design files
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// word and route
`define SSP_WORD_W 21
`define SSP_ROUTE_A 0
`define SSP_ROUTE_B 1
`define SSP_ROUTE_REF 2'h0
`define SSP_ROUTE_FUNC 2'h1
`define SSP_ROUTE_FB 2'h2
`define SSP_ROUTE_INIT 2'h3
`define SSP_DATA_MSB 20
`define SSP_DATA_LSB 2

// reference word fields
`define SSP_REF_LSB 2
`define SSP_REF_MSB 15
`define SSP_REF_TEST_LSB 16
`define SSP_REF_TEST_MSB 19
`define SSP_REF_PREC 20

// feedback word fields
`define SSP_SWAL_LSB 2
`define SSP_SWAL_MSB 6
`define SSP_SWAL_NARROW_MSB 4
`define SSP_MAIN_LSB 7
`define SSP_MAIN_MSB 19
`define SSP_GO 20

// function word fields
`define SSP_F_CRST 2
`define SSP_F_PDN 3
`define SSP_F_MUX_LSB 4
`define SSP_F_MUX_MID 5
`define SSP_F_MUX_MSB 6
`define SSP_F_POL 7
`define SSP_F_HIZ 8
`define SSP_F_ACQ_EN 9
`define SSP_F_ACQ_CTL 10
`define SSP_F_TO_EN 11
`define SSP_F_TO_LSB 12
`define SSP_F_TO_MSB 15
`define SSP_F_TEST_LSB 16
`define SSP_F_TEST_MSB 18
`define SSP_F_PDN_STYLE 19
`define SSP_F_TEST_LAST 20

// latch widths and reset values
`define SSP_LATCH_W 19
`define SSP_REF_RST 19'h00000
`define SSP_FB_RST 19'h00000
`define SSP_FUNC_RST 19'h00001
`define SSP_SR_RST 21'h000000

// prescaler moduli, shift amounts
`define SSP_MOD_SHIFT_NARROW 3
`define SSP_MOD_SHIFT_WIDE 5

// multiplexed output selector codes
`define SSP_MUX_HIZ 3'h0
`define SSP_MUX_REF 3'h1
`define SSP_MUX_FB 3'h2
`define SSP_MUX_SDO 3'h3
`define SSP_MUX_LOCK 3'h4
`define SSP_MUX_LOCK_OD 3'h5
`define SSP_MUX_HIGH 3'h6
`define SSP_MUX_LOW 3'h7

// lock detect cycle counts
`define SSP_LOCK_FINE 3'h5
`define SSP_LOCK_COARSE 3'h3

`endif

// file: rtl/ssp_sync.v
// three-flop synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clk_in
module ssp_sync (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // pin and filtered level
    input wire pin_in,
    output wire level_out
);

reg s1_ff;
reg s2_ff;
reg s3_ff;
reg level_ff;

// level only moves once the second and third stages agree
always @(posedge clk_in) begin
    if (rst_in) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        s3_ff <= 1'b0;
        level_ff <= 1'b0;
    end else begin
        s1_ff <= pin_in;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff) begin
            level_ff <= s3_ff;
        end
    end
end

assign level_out = level_ff;

endmodule // ssp_sync

// file: rtl/ssp_top.v
// serial programming front end: shift register and three latches
// assumes pins arrive asynchronously; divider, lock and pump pulses are
// on mclk_in
//
// Functional notes
// RULE1 - 21 bits MSB first, last two route
// RULE2 - route 00 loads reference latch, 14-bit ratio
// RULE3 - host writes reference test bits zero
// RULE4 - host keeps reference ratio 3 to 16383
// RULE5 - reference bits 1..14 plain binary ratio
// RULE6 - route 10 loads swallow, main, go bit
// RULE7 - feedback bits 6..18 plain binary main count
// RULE8 - host keeps main 3..8191, not below swallow
// RULE9 - narrow prescaler uses swallow bits 1..3
// RULE10 - total division modulus times main plus swallow
// RULE11 - host keeps total division in variant range
// RULE12 - function and init routes share registers
// RULE13 - counter reset bit holds both counters reset
// RULE14 - bit 6 selects detector polarity
// RULE15 - bit 7 puts charge pump high impedance
// RULE16 - bit 8 enables four acquisition modes
// RULE17 - bit 8 clear: aux pin follows bit 9
// RULE18 - bit 10 timeout enable, 11..14 value
// RULE19 - host writes function test bits zero
// RULE20 - bits 3..5 select multiplexed output
// RULE21 - multiplexed output selector code table
// RULE22 - power down via enable pin, bits 2, 18
// RULE23 - lock precision picks five or three cycles
// RULE24 - data sampled on clock rise, strobe loads
// RULE25 - latches change only on load strobe
module ssp_top #(
    // 1 selects the 32/33 prescaler, 0 the 8/9 prescaler
    parameter WIDE_PRESCALER = 1
) (
    // clock and reset
    input wire mclk_in,
    input wire rst_in,
    // serial programming link
    input wire ser_data_in,
    input wire ser_clk_in,
    input wire latch_strobe_in,
    // chip enable pin
    input wire chip_enable_in,
    // synthesizer core events, on mclk_in
    input wire ref_div_pulse_in,
    input wire fb_div_pulse_in,
    input wire lock_detect_in,
    input wire pump_event_in,
    // divider settings
    output wire [13:0] ref_ratio_out,
    output wire [4:0] swallow_count_out,
    output wire [12:0] main_count_out,
    output wire [17:0] total_div_out,
    output wire accel_go_out,
    // loop control
    output wire counter_reset_out,
    output wire power_down_out,
    output wire detector_polarity_out,
    output wire pump_high_z_out,
    output wire lock_precision_out,
    output wire [2:0] lock_cycles_out,
    // rapid acquisition
    output wire acquisition_active_out,
    output wire [1:0] acquisition_mode_out,
    output wire timeout_enable_out,
    output wire [3:0] timeout_value_out,
    // pins
    output wire auxiliary_output_pin_out,
    output wire multiplexed_output_pin_out,
    output wire multiplexed_output_pin_oe_out
);

`include "ssp_consts.vh"

////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire data_lvl;
wire sclk_lvl;
wire strobe_lvl;
wire ce_lvl;

ssp_sync u_sync_data (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .pin_in(ser_data_in),
    .level_out(data_lvl)
);

ssp_sync u_sync_sclk (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .pin_in(ser_clk_in),
    .level_out(sclk_lvl)
);

ssp_sync u_sync_strobe (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .pin_in(latch_strobe_in),
    .level_out(strobe_lvl)
);

ssp_sync u_sync_ce (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .pin_in(chip_enable_in),
    .level_out(ce_lvl)
);

////////////////////////////////////////////////////////////////////////
// edge detection

reg sclk_prev_ff;
reg strobe_prev_ff;
wire sclk_rise;
wire strobe_rise;

always @(posedge mclk_in) begin
    if (rst_in) begin
        sclk_prev_ff <= 1'b0;
        strobe_prev_ff <= 1'b0;
    end else begin
        sclk_prev_ff <= sclk_lvl;
        strobe_prev_ff <= strobe_lvl;
    end
end

// data and clock see the same synchroniser delay, so the 50 ns setup
// at the pins still holds after sampling
assign sclk_rise = sclk_lvl & ~sclk_prev_ff; // [RULE24]
assign strobe_rise = strobe_lvl & ~strobe_prev_ff; // [RULE24]

////////////////////////////////////////////////////////////////////////
// shift register

reg [`SSP_WORD_W-1:0] shift_ff;
wire [`SSP_WORD_W-1:0] nxt_shift;
wire [1:0] route;

// newest bit enters at the bottom, so the first (msb) ends on top
assign nxt_shift = {shift_ff[`SSP_WORD_W-2:0], data_lvl}; // [RULE1]

always @(posedge mclk_in) begin
    if (rst_in) begin
        shift_ff <= `SSP_SR_RST;
    end else if (sclk_rise) begin
        shift_ff <= nxt_shift; // [RULE24]
    end
end

// last two bits received pick the destination
assign route = {shift_ff[`SSP_ROUTE_A], shift_ff[`SSP_ROUTE_B]}; // [RULE1]

////////////////////////////////////////////////////////////////////////
// latches

reg [`SSP_LATCH_W-1:0] ref_latch_ff;
reg [`SSP_LATCH_W-1:0] fb_latch_ff;
reg [`SSP_LATCH_W-1:0] func_latch_ff;
wire [`SSP_LATCH_W-1:0] word_data;

assign word_data = shift_ff[`SSP_DATA_MSB:`SSP_DATA_LSB];

// shifting alone never touches a latch; only the strobe copies a word
always @(posedge mclk_in) begin
    if (rst_in) begin
        ref_latch_ff <= `SSP_REF_RST;
        fb_latch_ff <= `SSP_FB_RST;
        func_latch_ff <= `SSP_FUNC_RST;
    end else if (strobe_rise) begin // [RULE25]
        case (route)
            `SSP_ROUTE_REF: begin
                ref_latch_ff <= word_data; // [RULE2]
            end
            `SSP_ROUTE_FB: begin
                fb_latch_ff <= word_data; // [RULE6]
            end
            `SSP_ROUTE_FUNC, `SSP_ROUTE_INIT: begin
                func_latch_ff <= word_data; // [RULE12]
            end
            default: begin
                func_latch_ff <= func_latch_ff;
            end
        endcase
    end
end

// views of the latches in shift register bit positions
wire [`SSP_WORD_W-1:0] ref_word;
wire [`SSP_WORD_W-1:0] fb_word;
wire [`SSP_WORD_W-1:0] fn_word;

assign ref_word = {ref_latch_ff, 2'h0};
assign fb_word = {fb_latch_ff, 2'h0};
assign fn_word = {func_latch_ff, 2'h0};

////////////////////////////////////////////////////////////////////////
// divider decoding

wire [13:0] ref_ratio;
wire [4:0] swallow_raw;
wire [4:0] swallow_eff;
wire [12:0] main_count;
wire [17:0] total_div;

// test bits of the reference word are stored but have no effect
assign ref_ratio = ref_word[`SSP_REF_MSB:`SSP_REF_LSB]; // [RULE5]
assign main_count = fb_word[`SSP_MAIN_MSB:`SSP_MAIN_LSB]; // [RULE7]
assign swallow_raw = fb_word[`SSP_SWAL_MSB:`SSP_SWAL_LSB]; // [RULE6]

generate
    if (WIDE_PRESCALER != 0) begin : g_wide
        assign swallow_eff = swallow_raw; // [RULE9]
        assign total_div = ({5'h00, main_count} << `SSP_MOD_SHIFT_WIDE)
            + {13'h0000, swallow_eff}; // [RULE10]
    end else begin : g_narrow
        assign swallow_eff = {2'h0,
            swallow_raw[`SSP_SWAL_NARROW_MSB-`SSP_SWAL_LSB:0]}; // [RULE9]
        assign total_div = ({5'h00, main_count} << `SSP_MOD_SHIFT_NARROW)
            + {13'h0000, swallow_eff}; // [RULE10]
    end
endgenerate

// ratios outside the legal ranges are passed through unchecked; the
// divider core must not be given them by the host

////////////////////////////////////////////////////////////////////////
// power down

reg sync_pd_ff;
wire pdn_bit;
wire pdn_style;
wire power_down;

assign pdn_bit = fn_word[`SSP_F_PDN];
assign pdn_style = fn_word[`SSP_F_PDN_STYLE];

// synchronous style waits for the next pump event, then holds until the
// power down bit is cleared
always @(posedge mclk_in) begin
    if (rst_in) begin
        sync_pd_ff <= 1'b0;
    end else if (!pdn_bit) begin
        sync_pd_ff <= 1'b0; // [RULE22]
    end else if (pump_event_in) begin
        sync_pd_ff <= 1'b1; // [RULE22]
    end
end

assign power_down = ~ce_lvl
    | (pdn_bit & ~pdn_style)
    | (pdn_bit & pdn_style & sync_pd_ff); // [RULE22]

////////////////////////////////////////////////////////////////////////
// function decoding

wire [2:0] mux_sel;
wire acq_en;
wire acq_ctl;
wire lock_prec;

// the first field bit is the most significant bit of the code
assign mux_sel = {fn_word[`SSP_F_MUX_LSB], fn_word[`SSP_F_MUX_MID],
    fn_word[`SSP_F_MUX_MSB]}; // [RULE20]
assign acq_en = fn_word[`SSP_F_ACQ_EN];
assign acq_ctl = fn_word[`SSP_F_ACQ_CTL];
assign lock_prec = ref_word[`SSP_REF_PREC];

// power down forces counters to load state and floats the pump
assign counter_reset_out = fn_word[`SSP_F_CRST] | power_down; // [RULE13]
assign pump_high_z_out = fn_word[`SSP_F_HIZ] | power_down; // [RULE15]
assign detector_polarity_out = fn_word[`SSP_F_POL]; // [RULE14]
assign power_down_out = power_down;

assign acquisition_active_out = acq_en; // [RULE16]
// mode index 0..3 from control bit and timeout enable; enable bit qualifies
assign acquisition_mode_out = acq_en ?
    {acq_ctl, fn_word[`SSP_F_TO_EN]} : 2'h0; // [RULE16]
assign accel_go_out = fb_word[`SSP_GO]; // [RULE6]
assign timeout_enable_out = fn_word[`SSP_F_TO_EN]; // [RULE18]
assign timeout_value_out = fn_word[`SSP_F_TO_MSB:`SSP_F_TO_LSB]; // [RULE18]

assign lock_precision_out = lock_prec;
assign lock_cycles_out = lock_prec ?
    `SSP_LOCK_FINE : `SSP_LOCK_COARSE; // [RULE23]

////////////////////////////////////////////////////////////////////////
// output pins

reg aux_ff;
reg mux_ff;
reg mux_oe_ff;
reg nxt_mux;
reg nxt_mux_oe;

// registering the pins costs one cycle of latency on divider pulses
always @* begin
    nxt_mux = 1'b0;
    nxt_mux_oe = 1'b1;
    case (mux_sel)
        `SSP_MUX_HIZ: begin
            nxt_mux_oe = 1'b0; // [RULE21]
        end
        `SSP_MUX_REF: begin
            nxt_mux = ref_div_pulse_in; // [RULE21]
        end
        `SSP_MUX_FB: begin
            nxt_mux = fb_div_pulse_in; // [RULE21]
        end
        `SSP_MUX_SDO: begin
            nxt_mux = shift_ff[`SSP_WORD_W-1]; // [RULE21]
        end
        `SSP_MUX_LOCK: begin
            nxt_mux = lock_detect_in & ~power_down; // [RULE21]
        end
        `SSP_MUX_LOCK_OD: begin
            // open drain: only ever pulls low, while out of lock or powered down
            nxt_mux = 1'b0;
            nxt_mux_oe = ~(lock_detect_in & ~power_down); // [RULE21]
        end
        `SSP_MUX_HIGH: begin
            nxt_mux = 1'b1; // [RULE21]
        end
        `SSP_MUX_LOW: begin
            nxt_mux = 1'b0; // [RULE21]
        end
        default: begin
            nxt_mux_oe = 1'b0;
        end
    endcase
end

always @(posedge mclk_in) begin
    if (rst_in) begin
        aux_ff <= 1'b0;
        mux_ff <= 1'b0;
        mux_oe_ff <= 1'b0;
    end else begin
        // while acquisition is enabled the pin belongs to that logic
        // and is held low here
        aux_ff <= acq_en ? 1'b0 : acq_ctl; // [RULE17]
        mux_ff <= nxt_mux;
        mux_oe_ff <= nxt_mux_oe;
    end
end

assign auxiliary_output_pin_out = aux_ff;
assign multiplexed_output_pin_out = mux_ff;
assign multiplexed_output_pin_oe_out = mux_oe_ff;

////////////////////////////////////////////////////////////////////////
// divider outputs

assign ref_ratio_out = ref_ratio; // [RULE2]
assign swallow_count_out = swallow_eff;
assign main_count_out = main_count;
assign total_div_out = total_div;

endmodule // ssp_top

// file: tb/ssp_host_model.sv
// host side of the three-wire programming link: shifts words out
// assumes the bench calls send and nothing else drives these wires
module ssp_host_model (
    // link wires
    output logic sdata_out,
    output logic sclk_out,
    output logic strobe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////
    // link clock stands low between frames
    initial begin
        sdata_out = 1'h0;
        sclk_out = 1'h0;
        strobe_out = 1'h0;
    end
    task automatic send(input logic [20:0] w, input logic load);
        for (int i = 20; i >= 0; i--) begin
            sdata_out = w[i];
            #80 sclk_out = 1'h1;
            #80 sclk_out = 1'h0;
        end
        // hold has run out: show the inverse so a late sample is caught
        sdata_out = ~w[0];
        if (load) begin
            #80 strobe_out = 1'h1;
            #80 strobe_out = 1'h0;
        end
    endtask
endmodule // ssp_host_model

// file: tb/ssp_top_asserts.sv
// concurrent checks on the ports of the programming front end
// assumes it is bound into ssp_top
module ssp_top_asserts #(
    parameter WIDE_PRESCALER = 1
) (
    // clock, reset, pins
    input wire mclk_in,
    input wire rst_in,
    input wire chip_enable_in,
    input wire latch_strobe_in,
    // decoded settings
    input wire [13:0] ref_ratio_out,
    input wire [4:0] swallow_count_out,
    input wire [12:0] main_count_out,
    input wire [17:0] total_div_out,
    input wire counter_reset_out,
    input wire power_down_out,
    input wire pump_high_z_out,
    input wire lock_precision_out,
    input wire [2:0] lock_cycles_out,
    input wire acquisition_active_out,
    input wire [1:0] acquisition_mode_out,
    input wire auxiliary_output_pin_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////
    wire [17:0] exp_total = WIDE_PRESCALER ?
        {main_count_out, 5'h00} + swallow_count_out :
        {2'h0, main_count_out, 3'h0} + swallow_count_out;
    // cycles since the strobe was last seen high, saturating
    logic [7:0] since_ff;
    always @(posedge mclk_in) begin
        if (rst_in || latch_strobe_in)
            since_ff <= 8'h00;
        else if (since_ff != 8'hFF)
            since_ff <= since_ff + 8'h01;
    end
    sequence ce_low_s;
        !chip_enable_in [*8];
    endsequence
    sequence acq_held_s;
        acquisition_active_out [*2];
    endsequence
    total_div_a: assert property (total_div_out == exp_total)
        else $error("total division wrong");
    narrow_swal_a: assert property (
        WIDE_PRESCALER != 0 || swallow_count_out[4:3] == 2'h0)
        else $error("narrow swallow high bits set");
    lock_cycles_a: assert property (
        lock_cycles_out == (lock_precision_out ? 3'h5 : 3'h3))
        else $error("lock cycle count wrong");
    acq_off_a: assert property (
        !acquisition_active_out |-> acquisition_mode_out == 2'h0)
        else $error("mode set without acquisition");
    aux_acq_a: assert property (
        acq_held_s |-> !auxiliary_output_pin_out)
        else $error("aux pin high during acquisition");
    pdn_effect_a: assert property (
        power_down_out |-> counter_reset_out && pump_high_z_out)
        else $error("power down without reset and high z");
    ce_pdn_a: assert property (ce_low_s |-> power_down_out)
        else $error("chip enable low but powered");
    latch_hold_a: assert property (
        $changed(ref_ratio_out) || $changed(main_count_out) ||
        $changed(swallow_count_out) |-> since_ff < 8'h0C)
        else $error("latch changed without strobe");
endmodule // ssp_top_asserts

bind ssp_top ssp_top_asserts #(.WIDE_PRESCALER(WIDE_PRESCALER))
    ssp_top_asserts_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .chip_enable_in(chip_enable_in), .latch_strobe_in(latch_strobe_in),
    .ref_ratio_out(ref_ratio_out), .swallow_count_out(swallow_count_out),
    .main_count_out(main_count_out), .total_div_out(total_div_out),
    .counter_reset_out(counter_reset_out), .power_down_out(power_down_out),
    .pump_high_z_out(pump_high_z_out),
    .lock_precision_out(lock_precision_out),
    .lock_cycles_out(lock_cycles_out),
    .acquisition_active_out(acquisition_active_out),
    .acquisition_mode_out(acquisition_mode_out),
    .auxiliary_output_pin_out(auxiliary_output_pin_out));

// file: tb/ssp_top_tb.sv
// self-checking bench for the serial programming front end
// assumes the host model and the bound checker are compiled with it
module ssp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0, rst = 1'h1, ce = 1'h1, pump = 1'h0;
    logic refp = 1'h1, fbp = 1'h0, lock = 1'h1;
    wire sd, sc, le, go, crst, pdn, pol, hiz, lp, acq, toe, aux, mx, moe;
    wire [13:0] rr;
    wire [4:0] sw;
    wire [12:0] mc;
    wire [17:0] td;
    wire [2:0] lc;
    wire [1:0] am;
    wire [3:0] tv;
    int bad_count = 0, n_tests = 0;
    always #10 mclk = ~mclk;
    ssp_host_model ssp_host_model_i (.sdata_out(sd), .sclk_out(sc),
        .strobe_out(le));
    ssp_top ssp_top_i (.mclk_in(mclk), .rst_in(rst), .ser_data_in(sd),
        .ser_clk_in(sc), .latch_strobe_in(le), .chip_enable_in(ce),
        .ref_div_pulse_in(refp), .fb_div_pulse_in(fbp),
        .lock_detect_in(lock), .pump_event_in(pump),
        .ref_ratio_out(rr), .swallow_count_out(sw), .main_count_out(mc),
        .total_div_out(td), .accel_go_out(go), .counter_reset_out(crst),
        .power_down_out(pdn), .detector_polarity_out(pol),
        .pump_high_z_out(hiz), .lock_precision_out(lp),
        .lock_cycles_out(lc), .acquisition_active_out(acq),
        .acquisition_mode_out(am), .timeout_enable_out(toe),
        .timeout_value_out(tv), .auxiliary_output_pin_out(aux),
        .multiplexed_output_pin_out(mx),
        .multiplexed_output_pin_oe_out(moe));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, m,
                got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // route argument is {second-last bit, last bit}
    task automatic prog(input logic [18:0] v, input logic [1:0] rt,
        input logic load = 1'h1);
        ssp_host_model_i.send({v, rt}, load);
        repeat (12) @(negedge mclk);
    endtask
    function automatic logic [18:0] fw(input logic [3:0] to,
        input logic f18, f10, f9, f8, f7, f6, input logic [2:0] m,
        input logic f2, f1);
        // mux code goes msb first into the lowest field bit
        return {1'h0, f18, 3'h0, to, f10, f9, f8, f7, f6, m[0], m[1],
            m[2], f2, f1};
    endfunction
    initial begin
        #600000;
        bad_count++;
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge mclk);
        rst = 1'h0;
        repeat (8) @(negedge mclk);
        chk(crst, 1, "reset counter hold");
        chk({rr, mc, sw}, 0, "latch reset");
        prog({1'h1, 4'h0, 14'h3FFF}, 2'h0);
        chk({rr, lp, lc}, {14'h3FFF, 1'h1, 3'h5}, "ref max");
        prog({1'h0, 4'h0, 14'h0003}, 2'h0);
        chk({rr, lp, lc}, {14'h0003, 1'h0, 3'h3}, "ref min");
        prog({1'h1, 13'h1FFF, 5'h1F}, 2'h1);
        chk({go, mc, sw, td}, {1'h1, 13'h1FFF, 5'h1F, 18'h3FFFF},
            "fb max");
        prog({1'h0, 13'h001F, 5'h00}, 2'h1);
        chk({go, mc, td}, {1'h0, 13'h001F, 18'h003E0}, "fb min");
        prog({1'h0, 4'h0, 14'h0100}, 2'h0, 1'h0);
        chk(rr, 14'h0003, "no strobe");
        prog({1'h0, 4'h0, 14'h0100}, 2'h0);
        chk(rr, 14'h0100, "after strobe");
        prog(fw(4'hA, 0, 1, 1, 0, 1, 1, 3'h6, 0, 0), 2'h2);
        chk({crst, pol, hiz, aux, acq, toe, tv}, 10'h1DA,
            "function word");
        for (int j = 0; j < 4; j++) begin
            prog(fw(4'h5, 0, j[0], j[1], 1, 0, 0, 3'h0, 0, 0),
                j[0] ? 2'h2 : 2'h3);
            chk({acq, am, aux, toe, tv, pol, hiz}, {1'h1, j[1:0], 1'h0,
                j[0], 4'h5, 2'h0}, "acquisition mode");
        end
        for (int i = 0; i < 8; i++) begin
            prog(fw(4'h0, 0, 0, 1, 0, 0, 0, i[2:0], 0, 0), 2'h2);
            chk(moe, i != 0 && i != 5, "mux enable");
            chk(aux, 1, "aux follows bit");
            if (i != 0)
                chk(mx, i == 1 || i == 4 || i == 6, "mux level");
        end
        prog(fw(4'h0, 0, 0, 0, 0, 0, 0, 3'h0, 1, 0), 2'h2);
        chk({pdn, crst, hiz}, 3'h7, "immediate down");
        prog(fw(4'h0, 0, 0, 0, 0, 0, 0, 3'h0, 0, 0), 2'h2);
        chk({pdn, crst, hiz, aux}, 4'h0, "powered up");
        prog(fw(4'h0, 1, 0, 0, 0, 0, 0, 3'h0, 1, 0), 2'h2);
        chk(pdn, 0, "waits for pump event");
        pump = 1'h1;
        @(negedge mclk);
        pump = 1'h0;
        repeat (3) @(negedge mclk);
        chk(pdn, 1, "down after pump event");
        prog(fw(4'h0, 0, 0, 0, 0, 0, 0, 3'h0, 0, 0), 2'h2);
        ce = 1'h0;
        repeat (10) @(negedge mclk);
        chk(pdn, 1, "chip enable low");
        report_and_stop;
    end
endmodule // ssp_top_tb
